// ===== dv/pdmc_cpu_model.sv
// cpu core model: apb master for the control registers plus sleep and wake strobes
module pdmc_cpu_model
    import pdmc_pkg::*;
(
    input  wire logic        CLK,           // clock
    output logic             PSEL,          // apb select
    output logic             PENABLE,       // apb access phase
    output logic             PWRITE,        // apb direction
    output logic      [31:0] PADDR,         // apb address
    output logic      [31:0] PWDATA,        // apb write data
    input  wire logic [31:0] PRDATA,        // apb read data
    input  wire logic        PREADY,        // apb ready
    input  wire logic        PSLVERR,       // apb error
    output logic             SLEEP_EXEC,    // sleep instruction strobe
    output logic             WAKE_IRQ,      // accepted wake interrupt
    output logic             TIMER_A_WATCH  // timer a watch select level
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {PSEL, PENABLE, PWRITE, PADDR, PWDATA, SLEEP_EXEC, WAKE_IRQ, TIMER_A_WATCH} = '0;

    ////////////////////////////////////////////////////////////////////////
    // one apb transfer; waits on ready as long as it takes, the bench watchdog ends a dead bus
    task automatic apb_xfer(input logic wr, input logic [31:0] a, input logic [7:0] d,
                            output logic [31:0] rdat, output logic err);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= {24'h0, d};
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        rdat = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        PWDATA <= ~PWDATA; // released data must not look valid
    endtask

    // one-cycle strobes and the watch select level; settle codes and noise select come from the bench, kept there
    task automatic sleep_op();
        @(posedge CLK) SLEEP_EXEC <= 1'b1;
        @(posedge CLK) SLEEP_EXEC <= 1'b0;
    endtask
    task automatic wake_op();
        @(posedge CLK) WAKE_IRQ <= 1'b1;
        @(posedge CLK) WAKE_IRQ <= 1'b0;
    endtask
    task automatic set_watch(input logic v);
        @(posedge CLK) TIMER_A_WATCH <= v;
    endtask
endmodule

// ===== dv/pdmc_power_mode_ctrl_monitor.sv
// checker: concurrent properties on the power-down mode control ports
module pdmc_power_mode_ctrl_monitor
    import pdmc_pkg::*;
(
    input wire logic        CLK,          // clock
    input wire logic        RSTN,         // async reset, active low
    input wire logic        PSEL,         // apb select
    input wire logic        PENABLE,      // apb access phase
    input wire logic        PWRITE,       // apb direction
    input wire logic [31:0] PADDR,        // apb address
    input wire logic [31:0] PRDATA,       // apb read data
    input wire logic        PREADY,       // apb ready
    input wire logic        PSLVERR,      // apb error
    input wire logic        SLEEP_EXEC,   // sleep strobe
    input wire logic        WAKE_IRQ,     // wake strobe
    input wire logic [2:0]  MODE,         // current mode
    input wire logic        CPU_RUN,      // cpu running
    input wire logic        CPU_ON_SUB,   // cpu on subclock
    input wire logic        SLEEP_DONE,   // sleep accepted
    input wire logic [2:0]  TARGET_MODE,  // captured target
    input wire logic [3:0]  SUBCLK_RATIO, // subactive divide
    input wire logic        NOISE_TICK    // sample strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    ////////////////////////////////////////////////////////////////////////
    // decode helpers for completed transfers
    logic mapped; // address hits one of the two registers
    logic acc;    // access cycle that completes at this edge
    assign mapped = (PADDR == PDMC_ADDR_CTRL_ONE) || (PADDR == PDMC_ADDR_CTRL_TWO);
    assign acc = PSEL && PENABLE && PREADY;

    ready_in_access_a: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready in access");
    unmapped_err_a: assert property (acc && !mapped |-> PSLVERR && PRDATA == 32'h0) else $error("unmapped ok");
    rsv_one_a: assert property (acc && !PWRITE && PADDR == PDMC_ADDR_CTRL_ONE |-> PRDATA[2:0] == 3'h7)
        else $error("ctrl one reserved bits");
    rsv_two_a: assert property (acc && !PWRITE && PADDR == PDMC_ADDR_CTRL_TWO |-> PRDATA[7:5] == 3'h7)
        else $error("ctrl two reserved bits");
    sleep_target_a: assert property (SLEEP_EXEC && MODE inside {3'h0, 3'h1, 3'h5}
        |=> SLEEP_DONE && TARGET_MODE == MODE) else $error("sleep not shown");
    halted_hold_a: assert property (MODE inside {3'h2, 3'h3, 3'h4, 3'h6} && !WAKE_IRQ |=> $stable(MODE))
        else $error("halted mode left");
    settle_halt_a: assert property (MODE == PDMC_SETTLE |-> !CPU_RUN ##1 MODE inside {3'h7, 3'h0, 3'h1})
        else $error("settle broken");
    sub_clock_a: assert property (CPU_ON_SUB == (MODE inside {3'h5, 3'h6})) else $error("clock source");
    ratio_frozen_a: assert property (MODE == PDMC_SUBACT |=> MODE != PDMC_SUBACT || $stable(SUBCLK_RATIO))
        else $error("ratio moved in subactive");
    noise_gap_a: assert property (NOISE_TICK |=> !NOISE_TICK [*3]) else $error("noise ticks too close");
    sleep_wake_a: assert property (MODE == PDMC_SLEEP && WAKE_IRQ |=> MODE inside {3'h0, 3'h1})
        else $error("sleep wake target");
endmodule

bind pdmc_power_mode_ctrl pdmc_power_mode_ctrl_monitor i_mon (
    .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP_EXEC(SLEEP_EXEC), .WAKE_IRQ(WAKE_IRQ),
    .MODE(MODE), .CPU_RUN(CPU_RUN), .CPU_ON_SUB(CPU_ON_SUB), .SLEEP_DONE(SLEEP_DONE),
    .TARGET_MODE(TARGET_MODE), .SUBCLK_RATIO(SUBCLK_RATIO), .NOISE_TICK(NOISE_TICK)
);

// ===== dv/tb_power_down_mode_control.sv
// testbench: registers, mode transitions, settle wait and clock selects
module tb_power_down_mode_control;
    timeunit 1ns;
    timeprecision 1ns;
    import pdmc_pkg::*;

    localparam int BASE = 4; // short settle base keeps the run small
    logic CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SLEEP_EXEC, WAKE_IRQ, TIMER_A_WATCH;
    logic CPU_RUN, SYSOSC_EN, CPU_ON_SUB, SLEEP_DONE, NOISE_TICK;
    logic [31:0] PADDR, PWDATA, PRDATA, rd;
    logic [2:0]  MODE, TARGET_MODE, SETTLE_CODE;
    logic [3:0]  SUBCLK_RATIO;
    logic        err;
    int          failures, checks_done, n;

    pdmc_power_mode_ctrl #(.SETTLE_BASE_STATES(BASE)) i_dut (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP_EXEC(SLEEP_EXEC), .WAKE_IRQ(WAKE_IRQ),
        .TIMER_A_WATCH(TIMER_A_WATCH), .MODE(MODE), .CPU_RUN(CPU_RUN), .SYSOSC_EN(SYSOSC_EN),
        .CPU_ON_SUB(CPU_ON_SUB), .SLEEP_DONE(SLEEP_DONE), .TARGET_MODE(TARGET_MODE),
        .SETTLE_CODE(SETTLE_CODE), .SUBCLK_RATIO(SUBCLK_RATIO), .NOISE_TICK(NOISE_TICK));
    pdmc_cpu_model i_cpu (.CLK(CLK), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP_EXEC(SLEEP_EXEC),
        .WAKE_IRQ(WAKE_IRQ), .TIMER_A_WATCH(TIMER_A_WATCH));

    initial CLK = 1'b0;
    always #50 CLK = ~CLK; // 10 MHz

    ////////////////////////////////////////////////////////////////////////
    // compare, verdict and bus helpers
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic finish_test();
        if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        i_cpu.apb_xfer(1'b1, a, d, rd, err);
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string nm);
        i_cpu.apb_xfer(1'b0, a, 8'h00, rd, err);
        check(nm, rd, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reserved bits, unmapped access, divide field and noise sampling
    task automatic t_regs();
        rd_chk(PDMC_ADDR_CTRL_ONE, 32'h07, "one_reset");
        rd_chk(PDMC_ADDR_CTRL_TWO, 32'he0, "two_reset");
        wr(PDMC_ADDR_CTRL_ONE, 8'h00);
        rd_chk(PDMC_ADDR_CTRL_ONE, 32'h07, "one_rsv");
        wr(PDMC_ADDR_CTRL_TWO, 8'h1f);
        rd_chk(PDMC_ADDR_CTRL_TWO, 32'hff, "two_all");
        i_cpu.apb_xfer(1'b0, 32'h0003ffc8, 8'h00, rd, err);
        check("unmapped_err", {31'h0, err}, 32'h1);
        for (int d = 0; d < 4; d++) begin
            wr(PDMC_ADDR_CTRL_TWO, 8'(d));
            @(posedge CLK);
            #1 check("ratio", {28'h0, SUBCLK_RATIO}, d > 1 ? 32'h2 : (d == 1 ? 32'h4 : 32'h8));
        end
        for (int s = 0; s < 2; s++) begin
            wr(PDMC_ADDR_CTRL_TWO, s ? 8'h10 : 8'h00); // fast sampling left on only for this pass
            repeat (3) begin
                n = 0;
                do begin
                    @(posedge CLK);
                    #1 n++;
                end while (NOISE_TICK !== 1'b1 && n < 40);
            end
            check("noise_period", n, s ? 32'h4 : 32'h10);
        end
        wr(PDMC_ADDR_CTRL_TWO, 8'h00);
    endtask

    // one sleep (with register setup) or one wake, then the resulting mode
    task automatic step(input logic [7:0] one, input logic [7:0] two, input logic w, input logic slp,
                        input pdmc_mode_t exp);
        if (slp) begin
            wr(PDMC_ADDR_CTRL_ONE, one);
            wr(PDMC_ADDR_CTRL_TWO, two);
            i_cpu.set_watch(w);
            i_cpu.sleep_op();
            #1 check("sleep_done", {31'h0, SLEEP_DONE}, 32'h1);
            check("target", {29'h0, TARGET_MODE}, {29'h0, exp});
        end else begin
            i_cpu.wake_op();
            #1;
        end
        check("mode", {29'h0, MODE}, {29'h0, exp});
        // cpu runs in active and subactive, system oscillator only in active, sleep and the settle wait
        check("run_osc", {30'h0, CPU_RUN, SYSOSC_EN},
              {30'h0, (exp inside {PDMC_ACT_HIGH, PDMC_ACT_MED, PDMC_SUBACT}),
               (exp inside {PDMC_ACT_HIGH, PDMC_ACT_MED, PDMC_SLEEP})});
    endtask

    // the table of transitions, ordinary and direct
    task automatic t_modes();
        step(8'h00, 8'h04, 1'b0, 1'b1, PDMC_SLEEP);
        step(8'h00, 8'h00, 1'b0, 1'b0, PDMC_ACT_MED);
        step(8'h00, 8'h08, 1'b0, 1'b1, PDMC_ACT_HIGH);
        step(8'h00, 8'h0c, 1'b0, 1'b1, PDMC_ACT_MED);
        step(8'h00, 8'h08, 1'b0, 1'b1, PDMC_ACT_HIGH);
        step(8'h88, 8'h08, 1'b1, 1'b1, PDMC_SUBACT);
        wr(PDMC_ADDR_CTRL_TWO, 8'h0b);
        rd_chk(PDMC_ADDR_CTRL_TWO, 32'he8, "div_frozen");
        check("ratio_frozen", {28'h0, SUBCLK_RATIO}, 32'h8);
        step(8'h08, 8'h00, 1'b1, 1'b1, PDMC_SUBSLEEP);
        step(8'h00, 8'h00, 1'b1, 1'b0, PDMC_SUBACT);
        step(8'h88, 8'h00, 1'b1, 1'b1, PDMC_WATCH);
        step(8'h00, 8'h00, 1'b1, 1'b0, PDMC_SUBACT);
        step(8'h80, 8'h0c, 1'b1, 1'b1, PDMC_ACT_MED);
    endtask

    // standby and watch exits wait the coded number of states
    task automatic t_settle();
        for (int c = 0; c < 8; c++) begin
            step({1'b1, 3'(c), 4'h0}, 8'h00, c[0], 1'b1, c[0] ? PDMC_WATCH : PDMC_STANDBY);
            check("settle_code", {29'h0, SETTLE_CODE}, c);
            i_cpu.wake_op();
            #1 n = 0;
            while (MODE === PDMC_SETTLE && n < 200) begin
                @(posedge CLK);
                #1 n++;
            end
            check("settle_len", n, c > 3 ? BASE << 4 : BASE << c);
            check("wake_mode", {29'h0, MODE}, {29'h0, PDMC_ACT_HIGH});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reset, scenarios and watchdog
    initial begin
        RSTN = 1'b0;
        failures = 0;
        checks_done = 0;
        repeat (5) @(posedge CLK);
        RSTN <= 1'b1;
        t_regs();
        t_modes();
        t_settle();
        finish_test();
    end
    initial begin
        #1_000_000;
        failures++;
        finish_test();
    end
endmodule

// ===== hw/pdmc_pkg.sv
// package: register map, field layout and mode codes of the power-down mode control
package pdmc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [15:0] PDMC_IDX_CTRL_ONE = 16'hfff0;
    localparam logic [15:0] PDMC_IDX_CTRL_TWO = 16'hfff1;
    localparam logic [31:0] PDMC_ADDR_CTRL_ONE = {14'h0000, PDMC_IDX_CTRL_ONE, 2'h0};
    localparam logic [31:0] PDMC_ADDR_CTRL_TWO = {14'h0000, PDMC_IDX_CTRL_TWO, 2'h0};

    // reset values
    localparam logic [7:0] PDMC_RST_CTRL_ONE = 8'h07;
    localparam logic [7:0] PDMC_RST_CTRL_TWO = 8'he0;

    // reserved bits read as ones
    localparam logic [7:0] PDMC_RSV_CTRL_ONE = 8'h07;
    localparam logic [7:0] PDMC_RSV_CTRL_TWO = 8'he0;

    ////////////////////////////////////////////////////////////////////////
    // control one field positions
    localparam int PDMC_B_STANDBY = 7;
    localparam int PDMC_B_STS_HI  = 6;
    localparam int PDMC_B_STS_LO  = 4;
    localparam int PDMC_B_LOWSPD  = 3;

    // control two field positions
    localparam int PDMC_B_NOISE   = 4;
    localparam int PDMC_B_DIRECT  = 3;
    localparam int PDMC_B_MEDSPD  = 2;
    localparam int PDMC_B_SUB_HI  = 1;
    localparam int PDMC_B_SUB_LO  = 0;

    ////////////////////////////////////////////////////////////////////////
    // settle wait: base count in states, doubled per code step up to code 4, codes 5..7 same as 4
    localparam int PDMC_SETTLE_BASE = 8192;
    localparam int PDMC_SETTLE_W    = 17;

    // noise sampling dividers of the oscillator clock
    localparam logic [3:0] PDMC_NOISE_DIV_SLOW = 4'hf; // /16 minus one
    localparam logic [3:0] PDMC_NOISE_DIV_FAST = 4'h3; // /4 minus one

    // subactive divide ratios
    localparam logic [3:0] PDMC_SUB_DIV8 = 4'h8;
    localparam logic [3:0] PDMC_SUB_DIV4 = 4'h4;
    localparam logic [3:0] PDMC_SUB_DIV2 = 4'h2;

    ////////////////////////////////////////////////////////////////////////
    // operating modes
    typedef enum logic [2:0] {
        PDMC_ACT_HIGH,
        PDMC_ACT_MED,
        PDMC_SLEEP,
        PDMC_STANDBY,
        PDMC_WATCH,
        PDMC_SUBACT,
        PDMC_SUBSLEEP,
        PDMC_SETTLE
    } pdmc_mode_t;

endpackage

// ===== hw/pdmc_power_mode_ctrl.sv
// power-down mode control: two control registers on apb and the mode sequencer
//
// Functional notes
// - standby clear: sleep or subsleep target
// - standby set: standby or watch target
// - active with standby: watch select decides
// - settle code picks 8k..128k state wait
// - settle wait before resuming from standby/watch
// - low speed picks subclock after watch
// - reserved bits read one, ignore writes
// - noise select: oscillator/16 or /4 sampling
// - direct off: only ordinary sleep targets
// - direct from high speed: medium or subactive
// - direct from medium speed: high or subactive
// - direct from subactive: high or medium
// - medium select picks active speed on wake
// - subclock divide: /8, /4, /2
// - subclock divide frozen in subactive
//
// Chosen here: the APB interface to the registers.
module pdmc_power_mode_ctrl
    import pdmc_pkg::*;
#(
    parameter int SETTLE_BASE_STATES = PDMC_SETTLE_BASE // shorten in simulation
) (
    input  wire logic        CLK,           // oscillator clock, 10 MHz
    input  wire logic        RSTN,          // async reset, active low
    input  wire logic        PSEL,          // apb select
    input  wire logic        PENABLE,       // apb access phase
    input  wire logic        PWRITE,        // apb direction
    input  wire logic [31:0] PADDR,         // apb byte address
    input  wire logic [31:0] PWDATA,        // apb write data
    output logic      [31:0] PRDATA,        // apb read data
    output logic             PREADY,        // apb ready
    output logic             PSLVERR,       // apb error on unmapped address
    input  wire logic        SLEEP_EXEC,    // pulse: cpu executed sleep
    input  wire logic        WAKE_IRQ,      // pulse: accepted wake interrupt
    input  wire logic        TIMER_A_WATCH, // watch select bit from timer a
    output logic      [2:0]  MODE,          // current operating mode
    output logic             CPU_RUN,       // cpu executes instructions
    output logic             SYSOSC_EN,     // system oscillator running
    output logic             CPU_ON_SUB,    // cpu clocked from subclock
    output logic             SLEEP_DONE,    // pulse: sleep completed
    output logic      [2:0]  TARGET_MODE,   // target mode at sleep
    output logic      [2:0]  SETTLE_CODE,   // settle code at sleep
    output logic      [3:0]  SUBCLK_RATIO,  // subactive divide of watch clock
    output logic             NOISE_TICK     // watch clock sample strobe
);

    ////////////////////////////////////////////////////////////////////////
    // all state in one struct
    typedef struct packed {
        logic [7:0]               ctrl_one;   // power_mode_control_one
        logic [7:0]               ctrl_two;   // power_mode_control_two
        pdmc_mode_t               mode;       // operating mode
        pdmc_mode_t               resume;     // mode after settle wait
        logic [PDMC_SETTLE_W-1:0] settle_cnt; // settle countdown
        logic [3:0]               noise_cnt;  // sampling divider
        logic [31:0]              prdata;     // read data
        logic                     pready;     // ready
        logic                     pslverr;    // error
        logic                     sleep_done; // completion pulse
        pdmc_mode_t               target;     // shown target
        logic [2:0]               settle_code;// shown settle code
        logic [3:0]               sub_ratio;  // divide ratio
        logic                     noise_tick; // sample strobe
        logic                     cpu_run;    // cpu running
        logic                     sysosc_en;  // oscillator on
        logic                     cpu_on_sub; // subclock selected
    } pdmc_state_t;

    pdmc_state_t s_r;   // registered state
    pdmc_state_t s_nxt; // next state

    // field views of the stored registers
    logic       standby_select;         // bit 7 of control one
    logic [2:0] settle_time_select;     // bits 6..4 of control one
    logic       low_speed_select;       // bit 3 of control one
    logic       noise_sample_select;    // bit 4 of control two
    logic       direct_transfer_select; // bit 3 of control two
    logic       medium_speed_select;    // bit 2 of control two
    logic [1:0] subclock_divide;        // bits 1..0 of control two

    assign standby_select         = s_r.ctrl_one[PDMC_B_STANDBY];
    assign settle_time_select     = s_r.ctrl_one[PDMC_B_STS_HI:PDMC_B_STS_LO];
    assign low_speed_select       = s_r.ctrl_one[PDMC_B_LOWSPD];
    assign noise_sample_select    = s_r.ctrl_two[PDMC_B_NOISE];
    assign direct_transfer_select = s_r.ctrl_two[PDMC_B_DIRECT];
    assign medium_speed_select    = s_r.ctrl_two[PDMC_B_MEDSPD];
    assign subclock_divide        = s_r.ctrl_two[PDMC_B_SUB_HI:PDMC_B_SUB_LO];

    ////////////////////////////////////////////////////////////////////////
    // settle wait length, minus one for the countdown
    function automatic logic [PDMC_SETTLE_W-1:0] settle_load(input logic [2:0] code);
        logic [PDMC_SETTLE_W:0] base;
        logic [PDMC_SETTLE_W:0] wait_len;
        base = (PDMC_SETTLE_W + 1)'(SETTLE_BASE_STATES);
        // top bit set means the longest wait, low bits ignored
        if (code[2]) begin
            wait_len = base << 4;
        end else begin
            wait_len = base << code[1:0];
        end
        settle_load = PDMC_SETTLE_W'(wait_len - 1'b1);
    endfunction

    // active mode chosen by the medium speed select
    function automatic pdmc_mode_t active_mode(input logic med);
        active_mode = med ? PDMC_ACT_MED : PDMC_ACT_HIGH;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // target of a sleep instruction from the current mode
    pdmc_mode_t sleep_target; // computed target
    logic       sleep_legal;  // sleep allowed in this mode

    always_comb begin
        sleep_target = s_r.mode;
        sleep_legal  = 1'b0;
        unique case (s_r.mode)
            PDMC_ACT_HIGH, PDMC_ACT_MED: begin
                sleep_legal = 1'b1;
                if (!standby_select) begin
                    sleep_target = PDMC_SLEEP;
                end else if (TIMER_A_WATCH) begin
                    sleep_target = PDMC_WATCH;
                end else begin
                    sleep_target = PDMC_STANDBY;
                end
                // direct transfers override the ordinary targets
                if (direct_transfer_select) begin
                    if (s_r.mode == PDMC_ACT_HIGH && !standby_select
                            && medium_speed_select && !low_speed_select) begin
                        sleep_target = PDMC_ACT_MED;
                    end
                    if (s_r.mode == PDMC_ACT_MED && !standby_select
                            && !medium_speed_select && !low_speed_select) begin
                        sleep_target = PDMC_ACT_HIGH;
                    end
                    if (standby_select && TIMER_A_WATCH && low_speed_select) begin
                        sleep_target = PDMC_SUBACT;
                    end
                end
            end
            PDMC_SUBACT: begin
                sleep_legal  = 1'b1;
                sleep_target = standby_select ? PDMC_WATCH : PDMC_SUBSLEEP;
                if (direct_transfer_select && standby_select && TIMER_A_WATCH
                        && !low_speed_select) begin
                    sleep_target = active_mode(medium_speed_select);
                end
            end
            PDMC_SLEEP, PDMC_STANDBY, PDMC_WATCH, PDMC_SUBSLEEP, PDMC_SETTLE: begin
                // cpu halted; no instruction can arrive
                sleep_legal = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    logic setup_phase; // first cycle of a transfer
    logic hit_one;     // address of control one
    logic hit_two;     // address of control two
    logic wr_commit;   // write takes effect this edge

    assign setup_phase = PSEL && !PENABLE;
    assign hit_one     = (PADDR == PDMC_ADDR_CTRL_ONE);
    assign hit_two     = (PADDR == PDMC_ADDR_CTRL_TWO);
    assign wr_commit   = PSEL && PENABLE && s_r.pready && PWRITE;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_nxt            = s_r;
        s_nxt.sleep_done = 1'b0;

        // apb: answer one cycle after setup, so every access lasts two cycles
        if (setup_phase) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = !(hit_one || hit_two);
            if (hit_one) begin
                s_nxt.prdata = {24'h000000, s_r.ctrl_one | PDMC_RSV_CTRL_ONE};
            end else if (hit_two) begin
                s_nxt.prdata = {24'h000000, s_r.ctrl_two | PDMC_RSV_CTRL_TWO};
            end else begin
                s_nxt.prdata = 32'h00000000;
            end
        end else if (PSEL && PENABLE && s_r.pready) begin
            // access completes; drop ready and error
            s_nxt.pready  = 1'b0;
            s_nxt.pslverr = 1'b0;
        end

        // register writes; reserved bits stay at one
        if (wr_commit && hit_one) begin
            s_nxt.ctrl_one = PWDATA[7:0] | PDMC_RSV_CTRL_ONE;
        end
        if (wr_commit && hit_two) begin
            s_nxt.ctrl_two = PWDATA[7:0] | PDMC_RSV_CTRL_TWO;
            // divide field frozen while cpu runs on it
            if (s_r.mode == PDMC_SUBACT) begin
                s_nxt.ctrl_two[PDMC_B_SUB_HI:PDMC_B_SUB_LO] = subclock_divide;
            end
        end

        // mode sequencer
        unique case (s_r.mode)
            PDMC_ACT_HIGH, PDMC_ACT_MED, PDMC_SUBACT: begin
                if (SLEEP_EXEC && sleep_legal) begin
                    s_nxt.mode        = sleep_target;
                    s_nxt.sleep_done  = 1'b1;
                    s_nxt.target      = sleep_target;
                    s_nxt.settle_code = settle_time_select;
                end
            end
            PDMC_SLEEP: begin
                if (WAKE_IRQ) begin
                    s_nxt.mode = active_mode(medium_speed_select);
                end
            end
            PDMC_SUBSLEEP: begin
                if (WAKE_IRQ) begin
                    s_nxt.mode = PDMC_SUBACT;
                end
            end
            PDMC_STANDBY, PDMC_WATCH: begin
                if (WAKE_IRQ) begin
                    if (s_r.mode == PDMC_WATCH && low_speed_select) begin
                        // subclock kept running, no settle needed
                        s_nxt.mode = PDMC_SUBACT;
                    end else begin
                        s_nxt.mode       = PDMC_SETTLE;
                        s_nxt.resume     = active_mode(medium_speed_select);
                        s_nxt.settle_cnt = settle_load(settle_time_select);
                    end
                end
            end
            PDMC_SETTLE: begin
                // oscillator restarting; cpu held until count expires
                if (s_r.settle_cnt == '0) begin
                    s_nxt.mode = s_r.resume;
                end else begin
                    s_nxt.settle_cnt = s_r.settle_cnt - 1'b1;
                end
            end
        endcase

        // watch clock sampling strobe
        if (s_r.noise_cnt == '0) begin
            s_nxt.noise_tick = 1'b1;
            s_nxt.noise_cnt  = noise_sample_select ? PDMC_NOISE_DIV_FAST
                                                   : PDMC_NOISE_DIV_SLOW;
        end else begin
            s_nxt.noise_tick = 1'b0;
            s_nxt.noise_cnt  = s_r.noise_cnt - 1'b1;
        end

        // subactive divide ratio, top bit wins
        if (s_nxt.ctrl_two[PDMC_B_SUB_HI]) begin
            s_nxt.sub_ratio = PDMC_SUB_DIV2;
        end else if (s_nxt.ctrl_two[PDMC_B_SUB_LO]) begin
            s_nxt.sub_ratio = PDMC_SUB_DIV4;
        end else begin
            s_nxt.sub_ratio = PDMC_SUB_DIV8;
        end

        // status outputs decoded from the next mode so they align with it
        s_nxt.cpu_run    = (s_nxt.mode == PDMC_ACT_HIGH) || (s_nxt.mode == PDMC_ACT_MED)
                           || (s_nxt.mode == PDMC_SUBACT);
        s_nxt.sysosc_en  = (s_nxt.mode == PDMC_ACT_HIGH) || (s_nxt.mode == PDMC_ACT_MED)
                           || (s_nxt.mode == PDMC_SLEEP) || (s_nxt.mode == PDMC_SETTLE);
        s_nxt.cpu_on_sub = (s_nxt.mode == PDMC_SUBACT) || (s_nxt.mode == PDMC_SUBSLEEP);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            s_r             <= '0;
            s_r.ctrl_one    <= PDMC_RST_CTRL_ONE;
            s_r.ctrl_two    <= PDMC_RST_CTRL_TWO;
            s_r.mode        <= PDMC_ACT_HIGH;
            s_r.resume      <= PDMC_ACT_HIGH;
            s_r.target      <= PDMC_ACT_HIGH;
            s_r.sub_ratio   <= PDMC_SUB_DIV8;
            s_r.noise_cnt   <= PDMC_NOISE_DIV_SLOW;
            s_r.cpu_run     <= 1'b1;
            s_r.sysosc_en   <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign PRDATA       = s_r.prdata;
    assign PREADY       = s_r.pready;
    assign PSLVERR      = s_r.pslverr;
    assign MODE         = s_r.mode;
    assign CPU_RUN      = s_r.cpu_run;
    assign SYSOSC_EN    = s_r.sysosc_en;
    assign CPU_ON_SUB   = s_r.cpu_on_sub;
    assign SLEEP_DONE   = s_r.sleep_done;
    assign TARGET_MODE  = s_r.target;
    assign SETTLE_CODE  = s_r.settle_code;
    assign SUBCLK_RATIO = s_r.sub_ratio;
    assign NOISE_TICK   = s_r.noise_tick;

endmodule
